/* File: rtl/fsfl_pkg.sv */
// Package of the flash status host controller: command port map, status word fields,
// result codes and flash command codes.
// Assumes one 25 MHz clock and a synchronous active-high reset.
package fsfl_pkg;

	// ------------------------------------------------------------
	// Command port register map
	// ------------------------------------------------------------
	localparam logic [3:0] REG_CTRL   = 4'h0;
	localparam logic [3:0] REG_STATUS = 4'h1;
	localparam logic [3:0] REG_RESULT = 4'h2;

	// Control register fields.
	localparam int CTRL_OP_LSB = 0;
	localparam int CTRL_GO_BIT = 4;
	localparam int CTRL_CLR_BIT = 5;
	localparam int CTRL_AUTOCLR_BIT = 6;

	// ------------------------------------------------------------
	// Status word fields
	// ------------------------------------------------------------
	localparam int SR_IDLE_BIT   = 7;
	localparam int SR_ESUSP_BIT  = 6;
	localparam int SR_EFAIL_BIT  = 5;
	localparam int SR_PFAIL_BIT  = 4;
	localparam int SR_VFAULT_BIT = 3;
	localparam int SR_PSUSP_BIT  = 2;
	localparam int SR_PROT_BIT   = 1;
	localparam logic [7:0] SR_MEANING_MASK = 8'hFE;
	localparam logic [7:0] SR_ERROR_MASK   = 8'h3A;

	// ------------------------------------------------------------
	// Result codes
	// ------------------------------------------------------------
	localparam logic [7:0] RES_READY      = 8'h80;
	localparam logic [7:0] RES_READY_ES   = 8'hC0;
	localparam logic [7:0] RES_PSUSP      = 8'h84;
	localparam logic [7:0] RES_PSUSP_ES   = 8'hC4;
	localparam logic [7:0] RES_P_CELL     = 8'h90;
	localparam logic [7:0] RES_P_CELL_ES  = 8'hD0;
	localparam logic [7:0] RES_P_PROGRAM_ENABLE_VOLTAGE     = 8'h98;
	localparam logic [7:0] RES_P_PROT     = 8'h92;
	localparam logic [7:0] RES_SEQ        = 8'hB0;
	localparam logic [7:0] RES_SEQ_ES     = 8'hF0;
	localparam logic [7:0] RES_E_PROGRAM_ENABLE_VOLTAGE     = 8'hA8;
	localparam logic [7:0] RES_E_PROT     = 8'hA2;
	localparam logic [7:0] RES_E_CELL     = 8'hA0;

	// ------------------------------------------------------------
	// Flash command codes and operations
	// ------------------------------------------------------------
	localparam logic [7:0] FCMD_READ_STATUS = 8'h70;
	localparam logic [7:0] FCMD_CLEAR       = 8'h50;
	localparam logic [7:0] FCMD_RESUME      = 8'hD0;
	localparam logic [7:0] FCMD_SUSPEND     = 8'hB0;

	// Bus timing: a read needs 90 ns for valid data.
	localparam int READ_NS     = 90;
	localparam int CLK_NS      = 40;
	localparam int READ_CYCLES = (READ_NS + CLK_NS - 1) / CLK_NS;

	typedef enum logic [2:0] {
		FSFL_ST_IDLE  = 3'b000,
		FSFL_ST_WCMD  = 3'b001,
		FSFL_ST_RSTAT = 3'b010,
		FSFL_ST_WAIT  = 3'b011,
		FSFL_ST_DONE  = 3'b100
	} fsfl_state_t;

	typedef struct packed {
		logic [7:0] data;
		logic       we_n;
		logic       oe_n;
	} fsfl_bus_t;

endpackage

/* File: rtl/fsfl_host.sv */
// Host controller that issues flash commands and polls the device status word.
// Assumes the flash data pins are driven back synchronously on flash_dq_in.
// How it works
// - Clear sticky flags before a new operation.
// - Trust suspend flag only while controller idle.
// - Mask the reserved least significant status bit.
// - Sample fail flags only after idle high.
//
// Added by the designer: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
module fsfl_host #(
	parameter int POLL_LIMIT = 1000000
) (
	input  wire logic       clk,
	input  wire logic       srst,
	input  wire logic [3:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	output logic      [7:0] reg_rdata,
	output logic      [7:0] flash_dq_out,
	output logic            flash_dq_oe_n,
	output logic            flash_we_n,
	output logic            flash_oe_n,
	input  wire logic [7:0] flash_dq_in,
	output logic            busy
);

	// The poll counter needs at least two cycles to tell a timeout from a first sample.
	if (POLL_LIMIT < 2) begin : g_poll_limit_check
		$error("POLL_LIMIT too small");
	end

	// ------------------------------------------------------------
	// Command port decode
	// ------------------------------------------------------------
	fsfl_pkg::fsfl_state_t state_reg, state_next;
	fsfl_pkg::fsfl_bus_t   bus_reg, bus_next;
	logic [7:0]  cmd_reg;
	logic [7:0]  status_reg;
	logic [7:0]  result_reg;
	logic        autoclr_reg;
	logic        clr_pend_reg;
	logic        timeout_reg;
	logic [1:0]  rdcnt_reg;
	logic [31:0] poll_reg;
	logic [7:0]  rdata_next;
	logic        busy_reg;

	wire wr_ctrl = reg_wr && (reg_addr == fsfl_pkg::REG_CTRL);
	wire in_idle = (state_reg == fsfl_pkg::FSFL_ST_IDLE);
	wire in_wait = (state_reg == fsfl_pkg::FSFL_ST_WAIT);
	// A command held back behind its clear still counts as busy, so orders are refused then.
	wire take_order = wr_ctrl && in_idle && !clr_pend_reg;
	wire start_op = take_order && reg_wdata[fsfl_pkg::CTRL_GO_BIT];
	wire start_clr = take_order && reg_wdata[fsfl_pkg::CTRL_CLR_BIT];

	// Mask out the reserved bit before any compare.
	wire [7:0] sample = flash_dq_in & fsfl_pkg::SR_MEANING_MASK;
	// Floating bits are meaningless while busy, only the idle bit is looked at.
	wire dev_idle = sample[fsfl_pkg::SR_IDLE_BIT];
	wire read_done = (rdcnt_reg == 2'(fsfl_pkg::READ_CYCLES));
	wire poll_out = (poll_reg == 32'(POLL_LIMIT));
	// Flags only count once the controller is idle; a suspend can still complete.
	wire take_status = in_wait && read_done && dev_idle;
	wire errors_set = |(status_reg & fsfl_pkg::SR_ERROR_MASK);
	// A stale error would make the new command look failed, so clear first.
	wire need_clear = autoclr_reg && errors_set;

	// ------------------------------------------------------------
	// Sequencer
	// ------------------------------------------------------------
	always_comb begin
		state_next = state_reg;
		bus_next = bus_reg;
		unique case (state_reg)
			fsfl_pkg::FSFL_ST_IDLE: begin
				bus_next.we_n = 1'b1;
				bus_next.oe_n = 1'b1;
				if (start_clr || (start_op && need_clear)) begin
					bus_next.data = fsfl_pkg::FCMD_CLEAR;
					bus_next.we_n = 1'b0;
					state_next = fsfl_pkg::FSFL_ST_WCMD;
				end else if (start_op || clr_pend_reg) begin
					bus_next.data = clr_pend_reg ? cmd_reg : reg_wdata;
					bus_next.we_n = 1'b0;
					state_next = fsfl_pkg::FSFL_ST_WCMD;
				end
			end
			fsfl_pkg::FSFL_ST_WCMD: begin
				bus_next.we_n = 1'b1;
				bus_next.oe_n = 1'b0;
				state_next = fsfl_pkg::FSFL_ST_RSTAT;
			end
			fsfl_pkg::FSFL_ST_RSTAT: begin
				// The status word follows the command without a separate read request.
				state_next = fsfl_pkg::FSFL_ST_WAIT;
			end
			fsfl_pkg::FSFL_ST_WAIT: begin
				if (take_status || poll_out) begin
					bus_next.oe_n = 1'b1;
					state_next = fsfl_pkg::FSFL_ST_DONE;
				end
			end
			fsfl_pkg::FSFL_ST_DONE: begin
				state_next = fsfl_pkg::FSFL_ST_IDLE;
			end
			default: begin
				state_next = fsfl_pkg::FSFL_ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			state_reg <= fsfl_pkg::FSFL_ST_IDLE;
			bus_reg <= '{data: 8'h00, we_n: 1'b1, oe_n: 1'b1};
		end else begin
			state_reg <= state_next;
			bus_reg <= bus_next;
		end
	end

	// ------------------------------------------------------------
	// Command holding and poll counters
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (srst) begin
			cmd_reg <= 8'h00;
			autoclr_reg <= 1'b0;
			clr_pend_reg <= 1'b0;
		end else begin
			if (take_order) begin
				autoclr_reg <= reg_wdata[fsfl_pkg::CTRL_AUTOCLR_BIT];
			end
			if (start_op) begin
				cmd_reg <= reg_wdata;
				clr_pend_reg <= need_clear && !start_clr;
			end else if (clr_pend_reg && in_idle) begin
				clr_pend_reg <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (srst || !in_wait) begin
			rdcnt_reg <= 2'h0;
			poll_reg <= 32'h0;
		end else begin
			rdcnt_reg <= read_done ? rdcnt_reg : rdcnt_reg + 2'h1;
			poll_reg <= poll_reg + 32'h1;
		end
	end

	// ------------------------------------------------------------
	// Captured status word and results
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (srst) begin
			status_reg <= fsfl_pkg::RES_READY;
			result_reg <= 8'h00;
			timeout_reg <= 1'b0;
		end else if (in_wait && (take_status || poll_out)) begin
			timeout_reg <= !take_status;
			status_reg <= take_status ? sample : status_reg;
			// Codes 84h/C4h, 80h/C0h, 90h..F0h are kept verbatim for software.
			result_reg <= take_status ? sample : result_reg;
		end
	end

	wire [7:0] status_view = {5'h00, timeout_reg, errors_set, busy_reg};
	wire [7:0] ctrl_view = {1'b0, autoclr_reg, 6'h00};
	assign rdata_next = (reg_addr == fsfl_pkg::REG_STATUS) ? status_view
		: (reg_addr == fsfl_pkg::REG_RESULT) ? result_reg
		: (reg_addr == fsfl_pkg::REG_CTRL) ? ctrl_view
		: 8'h00;

	always_ff @(posedge clk) begin
		if (srst) begin
			reg_rdata <= 8'h00;
			busy_reg <= 1'b0;
		end else begin
			reg_rdata <= reg_rd ? rdata_next : 8'h00;
			busy_reg <= (state_next != fsfl_pkg::FSFL_ST_IDLE) || clr_pend_reg;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign flash_dq_out = bus_reg.data;
	assign flash_dq_oe_n = bus_reg.we_n;
	assign flash_we_n = bus_reg.we_n;
	assign flash_oe_n = bus_reg.oe_n;
	assign busy = busy_reg;

endmodule

/* File: tb/fsfl_host_sva.sv */
// Checker of the host controller's command port and flash pins.
// Assumes the top module's ports only; bound below.
`timescale 1ns/1ps
module fsfl_host_sva (
	input wire logic       clk,
	input wire logic       srst,
	input wire logic [3:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic       reg_wr,
	input wire logic       reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic       flash_dq_oe_n,
	input wire logic       flash_we_n,
	input wire logic       flash_oe_n,
	input wire logic [7:0] flash_dq_in,
	input wire logic       busy
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);
	wire start = reg_wr && reg_addr == fsfl_pkg::REG_CTRL && (reg_wdata[4] || reg_wdata[5]) && !busy;
	wire res_rd = reg_rd && reg_addr == fsfl_pkg::REG_RESULT;
	sequence s_strobe;
		!flash_we_n ##1 flash_we_n && !flash_oe_n;
	endsequence
	AST_GO_STROBE: assert property (start |=> busy ##0 s_strobe)
		else $error("no command strobe after order");
	AST_DQ_ENABLE: assert property (flash_dq_oe_n == flash_we_n)
		else $error("data drive not tied to strobe");
	AST_NO_FIGHT: assert property (!flash_oe_n |-> flash_dq_oe_n && busy)
		else $error("host drives data while flash reads");
	AST_DONE_ON_IDLE: assert property ($rose(flash_oe_n) |-> $past(flash_dq_in[7]))
		else $error("poll ended before idle flag");
	AST_WAIT_MIN: assert property ($fell(flash_oe_n) |-> !flash_oe_n [*3])
		else $error("poll too short");
	AST_RDATA_QUIET: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
		else $error("read data outside read cycle");
	AST_IDLE_QUIET: assert property (!busy |-> flash_we_n && flash_oe_n)
		else $error("flash pins active while idle");
	AST_RESULT_MASK: assert property ($past(res_rd) |-> !reg_rdata[0])
		else $error("reserved bit not masked");
endmodule
bind fsfl_host fsfl_host_sva u_sva (.clk, .srst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
	.reg_rdata, .flash_dq_oe_n, .flash_we_n, .flash_oe_n, .flash_dq_in, .busy);

/* File: tb/fsfl_flash_model.sv */
// Behavioural flash status word answering the host's command strobes.
// Assumes the bench sets code to the outcome of the next operation.
`timescale 1ns/1ps
module fsfl_flash_model #(
	parameter int BUSY = 5
) (
	input wire logic       clk,
	input wire logic       srst,
	input wire logic [7:0] code,
	input wire logic [7:0] dq_out,
	input wire logic       we_n,
	input wire logic       oe_n,
	output logic     [7:0] dq_in
);
	logic [7:0] word_reg;
	logic [7:0] sticky_reg;
	logic [7:0] junk_reg;
	int         cnt;
	// Undriven pins show a moving pattern so a stale value never passes.
	always_ff @(posedge clk) begin
		junk_reg <= srst ? 8'hA5 : ~junk_reg;
		if (srst || (!we_n && dq_out == 8'h50)) begin
			sticky_reg <= 8'h00;
			word_reg <= 8'h80;
			cnt <= 0;
		end else if (!we_n) begin
			cnt <= BUSY;
			word_reg <= code | sticky_reg | 8'h01;
			sticky_reg <= sticky_reg | (code & 8'h3A);
		end else if (cnt > 0) begin
			cnt <= cnt - 1;
		end
	end
	assign dq_in = oe_n ? junk_reg : (cnt > 0) ? {1'b0, junk_reg[6:0]} : word_reg;
endmodule

/* File: tb/fsfl_host_bench.sv */
// Self-checking bench of the flash status host controller.
// Assumes the flash model stands on the far side of the flash pins.
`timescale 1ns/1ps
module fsfl_host_bench;
	logic       clk = 1'b0;
	logic       srst = 1'b1;
	logic       reg_wr = 1'b0;
	logic       reg_rd = 1'b0;
	logic [3:0] reg_addr = 4'h0;
	logic [7:0] reg_wdata = 8'h00;
	logic [7:0] code = 8'h80;
	logic [7:0] rd;
	logic [7:0] reg_rdata;
	logic [7:0] dq_out;
	logic [7:0] dq_in;
	logic       dq_oe_n;
	logic       we_n;
	logic       oe_n;
	logic       busy;
	int         fails = 0;
	int         n_checks = 0;
	logic [7:0] codes [13] = '{8'h80, 8'hC0, 8'h84, 8'hC4, 8'h90, 8'hD0, 8'h98, 8'h92,
		8'hB0, 8'hF0, 8'hA8, 8'hA2, 8'hA0};
	always #20 clk = ~clk;
	fsfl_host #(.POLL_LIMIT(50)) u_dut (.clk(clk), .srst(srst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.flash_dq_out(dq_out), .flash_dq_oe_n(dq_oe_n), .flash_we_n(we_n),
		.flash_oe_n(oe_n), .flash_dq_in(dq_in), .busy(busy));
	fsfl_flash_model u_flash (.clk(clk), .srst(srst), .code(code), .dq_out(dq_out),
		.we_n(we_n), .oe_n(oe_n), .dq_in(dq_in));
	task close_out;
		if (fails == 0 && n_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task check(input logic [7:0] seen, input logic [7:0] exp);
		n_checks++;
		if (seen !== exp) begin
			fails++;
			$display("wrong value at %0t: got %h want %h", $time, seen, exp);
		end
	endtask
	task wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task rdreg(input logic [3:0] a);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 rd = reg_rdata;
	endtask
	// Bounded wait; a hang counts as a mismatch and ends the run.
	task idle;
		for (int i = 0; i < 200; i++) begin
			@(posedge clk);
			#1 if (busy === 1'b0) return;
		end
		fails++;
		$display("wrong value at %0t: busy never fell", $time);
		close_out();
	endtask
	task op(input logic [7:0] cmd, input logic [7:0] c, input logic [7:0] exp);
		code <= c;
		wr(fsfl_pkg::REG_CTRL, cmd);
		idle();
		rdreg(fsfl_pkg::REG_RESULT);
		check(rd, exp);
	endtask
	initial begin
		repeat (3) @(posedge clk);
		srst <= 1'b0;
		for (int i = 0; i < 13; i++) begin
			op(8'h10, codes[i], codes[i] & 8'hFE);
			op(8'h10, 8'h80, 8'h80 | (codes[i] & 8'h3A));
			rdreg(fsfl_pkg::REG_STATUS);
			check(rd & 8'h07, {6'h00, |(codes[i] & 8'h3A), 1'b0});
			op(8'h20, 8'h80, 8'h80);
		end
		op(8'h10, 8'h98, 8'h98);
		wr(fsfl_pkg::REG_CTRL, 8'h40);
		rdreg(fsfl_pkg::REG_CTRL);
		check(rd, 8'h40);
		op(8'h58, 8'h80, 8'h80);
		wr(4'hF, 8'h10);
		@(posedge clk);
		#1 check({7'h00, busy}, 8'h00);
		code <= 8'h90;
		wr(fsfl_pkg::REG_CTRL, 8'h10);
		wr(fsfl_pkg::REG_CTRL, 8'h20);
		idle();
		op(8'h10, 8'h80, 8'h90);
		srst <= 1'b1;
		repeat (3) @(posedge clk);
		srst <= 1'b0;
		op(8'h10, 8'h80, 8'h80);
		close_out();
	end
endmodule
